// File: tvr_pkg.sv
// Constants for the fault value snapshot recorder
package tvr_pkg;
  localparam int unsigned CLK_HZ        = 50000000;
  localparam int unsigned PREFAULT_MS   = 100;
  localparam int unsigned FAULT_A_MS    = 10;
  localparam int unsigned FAULT_B_MS    = 20;
  localparam int unsigned SAMPLE_HZ     = 1000;
  localparam int unsigned SAMPLE_DIV    = CLK_HZ / SAMPLE_HZ;
  localparam int unsigned PRE_SAMPLES   = PREFAULT_MS * SAMPLE_HZ / 1000;
  localparam int unsigned FA_SAMPLES    = FAULT_A_MS * SAMPLE_HZ / 1000;
  localparam int unsigned FB_SAMPLES    = FAULT_B_MS * SAMPLE_HZ / 1000;
  localparam int unsigned HIST_DEPTH    = 128;
  localparam int unsigned SEC_W         = 16;
  localparam int unsigned PRI_W         = 32;
  localparam int unsigned RATIO_W       = 16;
  localparam int unsigned NCH           = 3;
  localparam logic [15:0] DIV_LAST      = 16'(SAMPLE_DIV - 1);
  localparam logic [6:0]  PRE_OFS       = 7'(PRE_SAMPLES);
  localparam logic [4:0]  FA_CNT        = 5'(FA_SAMPLES);
  localparam logic [4:0]  FB_CNT        = 5'(FB_SAMPLES);
  localparam logic [RATIO_W-1:0] RATIO_RST = 16'h0001;

  typedef enum logic [3:0] {
    TVR_IDLE  = 4'b0001,
    TVR_FAULT = 4'b0010,
    TVR_ARMED = 4'b0100,
    TVR_EMIT  = 4'b1000
  } tvr_state_t;
endpackage : tvr_pkg

// File: tvr_recorder.sv
// Fault value snapshot recorder: history, capture and trip-confirmed report
`timescale 1ns/100ps
// How it works
// RULE1: A rising start edge captures prefault and fault values of all three channels, then waits for trip.
// RULE2: The prefault value is the channel sample lying 100 ms before the start edge, from a rolling history.
// RULE3: The fault value is the mean of the samples taken 10 ms and 20 ms after the start edge.
// RULE4: A new start edge before any trip replaces the stored values with those of the newest edge.
// RULE5: After a start the block stays armed, holding values, until trip goes active.
// RULE6: A trip while armed emits events with all stored prefault and fault values for reporting; a trip that clears inside the 20 ms window emits nothing.
// RULE7: Secondary inputs are scaled to primary values by the transformer ratios before capture.
// RULE8: There are no settings; offsets and behaviour are fixed.
// RULE9: The driving logic should feed the general start and general trip to the two inputs.
// RULE10: A trip with no preceding start emits nothing, and after reporting the block returns to idle, or to fault capture on a start edge.
module tvr_recorder
  import tvr_pkg::*;
#(
  // Sample divider; fixed in use, simulation may shorten it
  parameter int unsigned TICK_DIV = SAMPLE_DIV
)
(
  // Clock, reset, enable
  input  wire logic                        sys_clk,
  input  wire logic                        resetn,
  input  wire logic                        clk_en,
  // Protection logic
  input  wire logic                        fault_start_input,
  input  wire logic                        fault_trip_input,
  // Secondary-side analog samples and transformer ratios
  input  wire logic signed [SEC_W-1:0]     sec_ch0,
  input  wire logic signed [SEC_W-1:0]     sec_ch1,
  input  wire logic signed [SEC_W-1:0]     sec_ch2,
  input  wire logic        [RATIO_W-1:0]   ratio_ch0,
  input  wire logic        [RATIO_W-1:0]   ratio_ch1,
  input  wire logic        [RATIO_W-1:0]   ratio_ch2,
  // Event report
  output logic                             event_valid,
  output logic signed [PRI_W-1:0]          prefault_ch0,
  output logic signed [PRI_W-1:0]          prefault_ch1,
  output logic signed [PRI_W-1:0]          prefault_ch2,
  output logic signed [PRI_W-1:0]          fault_ch0,
  output logic signed [PRI_W-1:0]          fault_ch1,
  output logic signed [PRI_W-1:0]          fault_ch2,
  output logic                             armed
);

  function automatic logic signed [PRI_W-1:0] to_primary(input logic signed [SEC_W-1:0] s,
                                                         input logic [RATIO_W-1:0] r);
    logic signed [PRI_W-1:0] p;
    p = PRI_W'(s) * PRI_W'($signed({1'b0, r}));
    return p;
  endfunction : to_primary

  function automatic logic signed [PRI_W-1:0] mean2(input logic signed [PRI_W-1:0] a,
                                                    input logic signed [PRI_W-1:0] b);
    logic signed [PRI_W:0] s;
    s = (PRI_W+1)'(a) + (PRI_W+1)'(b);
    return PRI_W'(s >>> 1);
  endfunction : mean2

  localparam logic [15:0]  TICK_LAST = 16'(TICK_DIV - 1);

  tvr_state_t              state_ff;
  logic [15:0]             div_ff;
  logic                    tick_ff;
  logic                    start_d_ff;
  logic                    trip_d_ff;
  logic [6:0]              wptr_ff;
  logic [4:0]              fcnt_ff;
  logic signed [PRI_W-1:0] hist0 [HIST_DEPTH];
  logic signed [PRI_W-1:0] hist1 [HIST_DEPTH];
  logic signed [PRI_W-1:0] hist2 [HIST_DEPTH];
  logic signed [PRI_W-1:0] cur0;
  logic signed [PRI_W-1:0] cur1;
  logic signed [PRI_W-1:0] cur2;
  logic signed [PRI_W-1:0] pre0_ff;
  logic signed [PRI_W-1:0] pre1_ff;
  logic signed [PRI_W-1:0] pre2_ff;
  logic signed [PRI_W-1:0] fa0_ff;
  logic signed [PRI_W-1:0] fa1_ff;
  logic signed [PRI_W-1:0] fa2_ff;
  logic signed [PRI_W-1:0] flt0_ff;
  logic signed [PRI_W-1:0] flt1_ff;
  logic signed [PRI_W-1:0] flt2_ff;
  logic                    start_rise;
  logic                    trip_rise;
  logic [6:0]              pre_idx;

  // RULE7 primary scaling
  assign cur0 = to_primary(sec_ch0, ratio_ch0);
  assign cur1 = to_primary(sec_ch1, ratio_ch1);
  assign cur2 = to_primary(sec_ch2, ratio_ch2);

  assign start_rise = fault_start_input & ~start_d_ff;
  assign trip_rise  = fault_trip_input & ~trip_d_ff;
  // RULE2 look back 100 samples
  assign pre_idx    = wptr_ff - PRE_OFS;

  // 1 kHz sample strobe at the default TICK_DIV; no run-time setting alters it
  // RULE8 fixed timing
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      div_ff  <= 16'h0000;
      tick_ff <= 1'b0;
    end else if (clk_en) begin
      tick_ff <= (div_ff == TICK_LAST);
      div_ff  <= (div_ff == TICK_LAST) ? 16'h0000 : div_ff + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      start_d_ff <= 1'b0;
      trip_d_ff  <= 1'b0;
    end else if (clk_en) begin
      start_d_ff <= fault_start_input;
      trip_d_ff  <= fault_trip_input;
    end
  end

  // RULE2 rolling history; array holds no reset, as a RAM would
  always_ff @(posedge sys_clk) begin
    if (clk_en && tick_ff) begin
      hist0[wptr_ff] <= cur0;
      hist1[wptr_ff] <= cur1;
      hist2[wptr_ff] <= cur2;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wptr_ff <= 7'h00;
    end else if (clk_en && tick_ff) begin
      wptr_ff <= wptr_ff + 7'h01;
    end
  end

  // Prefault snapshot on every start edge
  // RULE1 capture prefault
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pre0_ff <= '0;
      pre1_ff <= '0;
      pre2_ff <= '0;
    end else if (clk_en && start_rise) begin
      // RULE4 newest start overwrites
      pre0_ff <= hist0[pre_idx];
      pre1_ff <= hist1[pre_idx];
      pre2_ff <= hist2[pre_idx];
    end
  end

  // Fault window sampling; counter restarts on every start edge
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      fcnt_ff <= 5'h00;
      fa0_ff  <= '0;
      fa1_ff  <= '0;
      fa2_ff  <= '0;
      flt0_ff <= '0;
      flt1_ff <= '0;
      flt2_ff <= '0;
    end else if (clk_en) begin
      if (start_rise) begin
        fcnt_ff <= 5'h00;
      end else if (state_ff == TVR_FAULT && tick_ff) begin
        fcnt_ff <= fcnt_ff + 5'h01;
        // RULE3 sample at 10 ms
        if (fcnt_ff + 5'h01 == FA_CNT) begin
          fa0_ff <= cur0;
          fa1_ff <= cur1;
          fa2_ff <= cur2;
        end
        // RULE3 average at 20 ms
        if (fcnt_ff + 5'h01 == FB_CNT) begin
          flt0_ff <= mean2(fa0_ff, cur0);
          flt1_ff <= mean2(fa1_ff, cur1);
          flt2_ff <= mean2(fa2_ff, cur2);
        end
      end
    end
  end

  // Trip during the 20 ms window counts only if still active when the fault value exists
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_ff <= TVR_IDLE;
    end else if (clk_en) begin
      unique case (state_ff)
        TVR_IDLE: begin
          // RULE10 trip alone ignored
          if (start_rise) begin
            state_ff <= TVR_FAULT;
          end
        end
        TVR_FAULT: begin
          // RULE1 finish fault capture
          if (!start_rise && tick_ff && fcnt_ff + 5'h01 == FB_CNT) begin
            state_ff <= fault_trip_input ? TVR_EMIT : TVR_ARMED;
          end
        end
        TVR_ARMED: begin
          // RULE4 restart on new start
          if (start_rise) begin
            state_ff <= TVR_FAULT;
          // RULE5 wait for trip
          end else if (trip_rise || fault_trip_input) begin
            state_ff <= TVR_EMIT;
          end
        end
        TVR_EMIT: begin
          // RULE10 back to idle, or straight to TVR_FAULT on a start edge
          state_ff <= start_rise ? TVR_FAULT : TVR_IDLE;
        end
        default: state_ff <= TVR_IDLE;
      endcase
    end
  end

  // RULE6 event output
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      event_valid  <= 1'b0;
      armed        <= 1'b0;
      prefault_ch0 <= '0;
      prefault_ch1 <= '0;
      prefault_ch2 <= '0;
      fault_ch0    <= '0;
      fault_ch1    <= '0;
      fault_ch2    <= '0;
    end else if (clk_en) begin
      event_valid <= (state_ff == TVR_EMIT);
      armed       <= (state_ff == TVR_FAULT) || (state_ff == TVR_ARMED);
      if (state_ff == TVR_EMIT) begin
        prefault_ch0 <= pre0_ff;
        prefault_ch1 <= pre1_ff;
        prefault_ch2 <= pre2_ff;
        fault_ch0    <= flt0_ff;
        fault_ch1    <= flt1_ff;
        fault_ch2    <= flt2_ff;
      end
    end
  end

endmodule : tvr_recorder

// File: tvr_recorder_properties.sv
// Checker for the fault value snapshot recorder
`timescale 1ns/100ps
module tvr_recorder_chk
  import tvr_pkg::*;
#(
  parameter int unsigned TICK_DIV = SAMPLE_DIV
)
(
  // Clock and control
  input wire logic                    sys_clk,
  input wire logic                    resetn,
  input wire logic                    clk_en,
  input wire logic                    fault_start_input,
  input wire logic                    fault_trip_input,
  // Report
  input wire logic                    event_valid,
  input wire logic                    armed,
  input wire logic signed [PRI_W-1:0] prefault_ch0,
  input wire logic signed [PRI_W-1:0] fault_ch0
);
  // Window closes between the 19th and 20th sample period
  localparam int WIN  = 19 * TICK_DIV;
  localparam int DONE = 20 * TICK_DIV + 4;
  int   since_ff;
  logic start_q_ff;
  wire  rise = fault_start_input && !start_q_ff;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // Saturating cycles since newest start edge
  // Edge history moves only on enabled edges, as in the design
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      start_q_ff <= 1'b0;
      since_ff   <= 0;
    end else if (clk_en) begin
      start_q_ff <= fault_start_input;
      if (rise) since_ff <= 0;
      else if (since_ff < DONE) since_ff <= since_ff + 1;
    end
  end
  AST_START_ARMS: assert property (rise && clk_en ##1 clk_en |=> armed)
    else $error("armed not set after start edge");
  AST_STAY_ARMED: assert property (armed && !fault_trip_input && !$past(fault_trip_input) |=> armed)
    else $error("armed dropped without trip");
  AST_EV_ONE_CYCLE: assert property (event_valid && clk_en |=> !event_valid)
    else $error("event pulse longer than one cycle");
  AST_EV_WHEN_ARMED: assert property (event_valid |-> $past(armed) && !armed)
    else $error("event without armed state");
  AST_EV_AFTER_WINDOW: assert property (event_valid |-> since_ff >= WIN)
    else $error("event before fault window closed");
  AST_TRIP_REPORTS: assert property (armed && fault_trip_input && clk_en && since_ff >= DONE
    |-> ##[1:2] event_valid)
    else $error("trip while armed gave no event");
  AST_VALUES_HOLD: assert property (!event_valid |-> $stable(prefault_ch0) && $stable(fault_ch0))
    else $error("values changed without event");
  AST_IDLE_STAYS: assert property (!armed && !rise && !$past(rise) && clk_en && $past(clk_en) |=> !armed)
    else $error("armed without start edge");
  cover property (rise);
  cover property (event_valid);
  cover property (armed && fault_trip_input && since_ff < WIN);
  cover property (armed && fault_trip_input && since_ff >= DONE);
endmodule : tvr_recorder_chk

bind tvr_recorder tvr_recorder_chk #(.TICK_DIV(TICK_DIV)) u_chk (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en),
  .fault_start_input(fault_start_input), .fault_trip_input(fault_trip_input),
  .event_valid(event_valid), .armed(armed), .prefault_ch0(prefault_ch0), .fault_ch0(fault_ch0));

// File: tvr_prot_model.sv
// Protection start and trip logic model
`timescale 1ns/100ps
module tvr_prot_model (
  // Clock
  input  wire logic sys_clk,
  // General start and trip
  output logic      fault_start_input,
  output logic      fault_trip_input
);
  initial begin
    fault_start_input = 1'b0;
    fault_trip_input  = 1'b0;
  end
  task automatic start_edge();
    @(negedge sys_clk) fault_start_input <= 1'b0;
    @(negedge sys_clk) fault_start_input <= 1'b1;
  endtask : start_edge
  task automatic set_trip(input logic v);
    @(negedge sys_clk) fault_trip_input <= v;
  endtask : set_trip
endmodule : tvr_prot_model

// File: tvr_recorder_tb.sv
// Self-checking bench for the fault value snapshot recorder
`timescale 1ns/100ps
module tvr_recorder_tb;
  import tvr_pkg::*;
  // Short sample period keeps the run small
  localparam int           BENCH_DIV = 400;
  logic                    sys_clk = 1'b0;
  logic                    resetn = 1'b0;
  logic                    en = 1'b1;
  logic                    start, trip, ev, arm;
  logic signed [SEC_W-1:0] sec [NCH];
  logic [RATIO_W-1:0]      rat [NCH];
  logic signed [PRI_W-1:0] pre [NCH], flt [NCH];
  int num_errors = 0, tests_run = 0, seed = 32'h07f3, cyc = 0, nupd = 0, t, seen;
  int pq [NCH][$];
  tvr_prot_model prot (.sys_clk(sys_clk), .fault_start_input(start), .fault_trip_input(trip));
  tvr_recorder #(.TICK_DIV(BENCH_DIV)) uut (.sys_clk(sys_clk), .resetn(resetn), .clk_en(en), .fault_start_input(start),
    .fault_trip_input(trip), .sec_ch0(sec[0]), .sec_ch1(sec[1]), .sec_ch2(sec[2]), .ratio_ch0(rat[0]),
    .ratio_ch1(rat[1]), .ratio_ch2(rat[2]), .event_valid(ev), .prefault_ch0(pre[0]), .prefault_ch1(pre[1]),
    .prefault_ch2(pre[2]), .fault_ch0(flt[0]), .fault_ch1(flt[1]), .fault_ch2(flt[2]), .armed(arm));
  always #10 sys_clk = ~sys_clk;
  // New samples mid-way between ticks, so divider phase slips do not matter
  always @(negedge sys_clk) begin
    if (resetn) cyc <= cyc + 1;
    if (resetn && cyc % BENCH_DIV == BENCH_DIV / 2) begin
      for (int c = 0; c < NCH; c++) begin
        logic signed [SEC_W-1:0] v;
        logic [RATIO_W-1:0]      r;
        v = 16'($random(seed));
        r = 16'($random(seed));
        sec[c] <= v;
        rat[c] <= r;
        pq[c].push_back(int'(v) * int'(r));
      end
      nupd <= nupd + 1;
    end
  end
  task automatic check(input string what, input logic signed [PRI_W-1:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check
  task automatic wait_upd(input int k);
    while (nupd < k) @(negedge sys_clk);
  endtask : wait_upd
  task automatic capture(output int tk);
    prot.start_edge();
    tk = nupd - 1;
  endtask : capture
  task automatic expect_event(input int tk);
    int n;
    n = 0;
    do begin @(posedge sys_clk); #1; n++; end while (ev !== 1'b1 && n < 30 * BENCH_DIV);
    check("event", 32'h1, 32'(ev));
    for (int c = 0; c < NCH; c++) begin
      // Hundredth tick before the start edge
      check("prefault", pq[c][tk-99], pre[c]);
      check("fault", 32'((longint'(pq[c][tk+10]) + pq[c][tk+20]) >>> 1), flt[c]);
    end
    @(posedge sys_clk); #1;
    check("armed", 32'h0, 32'(arm));
  endtask : expect_event
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    for (int c = 0; c < NCH; c++) begin
      rat[c] = 16'($random(seed));
      sec[c] = 16'($random(seed));
      pq[c].push_back(int'(sec[c]) * int'(rat[c]));
    end
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk) resetn = 1'b1;
    wait_upd(103);
    seen = 0;
    prot.set_trip(1'b1);
    repeat (20) begin @(posedge sys_clk); #1; seen |= ev; end
    check("no event", 32'h0, 32'(seen));
    prot.set_trip(1'b0);
    $display("test trip_without_start done");
    wait_upd(110);
    capture(t);
    repeat (2) @(posedge sys_clk); #1;
    check("armed", 32'h1, 32'(arm));
    // Paused enable must freeze the capture
    @(negedge sys_clk) en <= 1'b0;
    repeat (5) @(negedge sys_clk);
    check("armed frozen", 32'h1, 32'(arm));
    en <= 1'b1;
    wait_upd(nupd + 5);
    // Trip inside the window must wait for the fault value
    prot.set_trip(1'b1);
    expect_event(t);
    prot.set_trip(1'b0);
    $display("test early_trip done");
    wait_upd(nupd + 2);
    capture(t);
    prot.set_trip(1'b1);
    wait_upd(nupd + 5);
    capture(t);
    expect_event(t);
    prot.set_trip(1'b0);
    $display("test restart done");
    wait_upd(nupd + 2);
    capture(t);
    wait_upd(nupd + 22);
    check("armed held", 32'h1, 32'(arm));
    prot.set_trip(1'b1);
    expect_event(t);
    prot.set_trip(1'b0);
    $display("test late_trip done");
    test_done();
  end
  // Run ends near 72k cycles; give up at 100k
  initial begin
    #2000000;
    num_errors++;
    test_done();
  end
endmodule : tvr_recorder_tb
